// ==== hw/gsbs_map.vh ====
// Register offsets, field positions, reset values and codes of the
// group status bus share block.
// Assumes inclusion by bare name from the design files.
`ifndef GSBS_MAP_VH
`define GSBS_MAP_VH
`define GSBS_ADDR_W 8
`define GSBS_DATA_W 8
`define GSBS_OFF_CTRL_ONE 8'hB0
`define GSBS_OFF_CTRL_TWO 8'hB1
`define GSBS_OFF_INFO_IRQ 8'hB2
`define GSBS_OFF_INFO_SYNC 8'hB3
`define GSBS_OFF_INFO_UA 8'hB4
`define GSBS_OFF_INFO_UB 8'hB5
`define GSBS_RST_CTRL_ONE 8'h00
`define GSBS_RST_CTRL_TWO 8'h00
`define GSBS_CTRL_ONE_MASK 8'h0F
`define GSBS_CTRL_TWO_MASK 8'h77
`define GSBS_EN_BIT 0
`define GSBS_LSEL_LO 1
`define GSBS_LSEL_HI 3
`define GSBS_UASEL_LO 0
`define GSBS_UASEL_HI 2
`define GSBS_UBSEL_LO 4
`define GSBS_UBSEL_HI 6
`define GSBS_GSEL_IRQ 2'h0
`define GSBS_GSEL_SYNC 2'h1
`define GSBS_GSEL_UA 2'h2
`define GSBS_GSEL_UB 2'h3
`define GSBS_CODE_ALM0 3'h0
`define GSBS_CODE_ALM1 3'h1
`define GSBS_CODE_ALM2 3'h2
`define GSBS_CODE_ALM3 3'h3
`define GSBS_CODE_SIGNALING_CHANGE 3'h4
`define GSBS_CODE_SLIP 3'h5
`endif

// ==== hw/gsbs_sync2.v ====
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes one clock; the clock enable freezes both stages.
`timescale 1ns/1ps
module gsbs_sync2 #(
   parameter W = 1
) (
   input wire mclk_i, // System clock
   input wire rst_b_i, // Async reset, active low
   input wire ce_i, // Clock enable
   input wire [W-1:0] d_i, // Asynchronous levels
   output wire [W-1:0] q_o // Synchronised levels
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // The first stage feeds only the second stage
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end else if (ce_i) begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;
endmodule

// ==== hw/gsbs_status_mux.v ====
// Picks the one status bit this member reports for a group read.
// Assumes status inputs are already on the system clock.
`timescale 1ns/1ps
`include "gsbs_map.vh"
module gsbs_status_mux (
   input wire [1:0] gsel_i, // Which information register
   input wire t1_mode_i, // 1 = T1 alarm set, 0 = E1 set
   input wire [2:0] ua_sel_i, // Status code for user register A
   input wire [2:0] ub_sel_i, // Status code for user register B
   input wire irq_i, // Interrupt pending
   input wire sync_loss_i, // Receive loss of frame sync
   input wire [5:0] t1_stat_i, // Blue,yellow,loopup,loopdn,sig,slip
   input wire [5:0] e1_stat_i, // Ua1,rai,dma,v52,sig,slip
   output reg bit_o // Selected status bit
);
   // One decoder for both user selects
   function pick;
      input [2:0] code;
      input [5:0] st;
      begin
         case (code)
            `GSBS_CODE_ALM0: pick = st[0];
            `GSBS_CODE_ALM1: pick = st[1];
            `GSBS_CODE_ALM2: pick = st[2];
            `GSBS_CODE_ALM3: pick = st[3];
            `GSBS_CODE_SIGNALING_CHANGE: pick = st[4];
            `GSBS_CODE_SLIP: pick = st[5];
            // Undefined codes report no alarm
            default: pick = 1'b0;
         endcase
      end
   endfunction

   wire [5:0] stat = t1_mode_i ? t1_stat_i : e1_stat_i;

   always @* begin
      case (gsel_i)
         `GSBS_GSEL_IRQ: bit_o = irq_i;
         `GSBS_GSEL_SYNC: bit_o = sync_loss_i;
         `GSBS_GSEL_UA: bit_o = pick(ua_sel_i, stat);
         default: bit_o = pick(ub_sel_i, stat);
      endcase
   end
endmodule

// ==== hw/gsbs_top.v ====
// Group status bus share: lets up to eight transceivers report one
// status bit each on a shared 8-bit host data bus in a single read.
// Assumes a synchronous register port on mclk_i; the shared select
// and strobe pins are open drain with external pull-ups.
`timescale 1ns/1ps
`include "gsbs_map.vh"
module gsbs_top (
   input wire mclk_i, // 250 MHz system clock
   input wire rst_b_i, // Async reset, active low
   input wire ce_i, // Clock enable, freezes state when low
   input wire [7:0] addr_i, // Register address
   input wire [7:0] wdata_i, // Write data
   input wire wr_i, // Write strobe, one cycle
   input wire rd_i, // Read strobe, held for the access
   output reg [7:0] rdata_o, // Read data, registered
   output wire [7:0] rdata_oe_o, // Per-line data drive enables
   input wire t1_mode_i, // 1 = T1 operation, 0 = E1
   input wire irq_i, // Device interrupt pending
   input wire sync_loss_i, // Receive loss of frame sync
   input wire [5:0] t1_stat_i, // T1 alarm set
   input wire [5:0] e1_stat_i, // E1 alarm set
   input wire group_sel_line0_i, // Shared select 0 pin level
   output wire group_sel_line0_o, // Shared select 0 drive value
   output wire group_sel_line0_oe_o, // Shared select 0 enable
   input wire group_sel_line1_i, // Shared select 1 pin level
   output wire group_sel_line1_o, // Shared select 1 drive value
   output wire group_sel_line1_oe_o, // Shared select 1 enable
   input wire group_read_strobe_i, // Shared strobe pin level
   output wire group_read_strobe_o, // Shared strobe drive value
   output wire group_read_strobe_oe_o // Shared strobe enable
);
   reg [7:0] ctrl_one_r;
   reg [7:0] ctrl_two_r;
   reg [1:0] own_gsel_r;
   reg own_rd_r;
   reg [1:0] own_echo_r;
   reg [7:0] rdata_nxt;
   reg [7:0] oe_r;
   reg [7:0] oe_nxt;
   wire [2:0] pin_sync;
   wire peer_rd;
   wire [1:0] peer_gsel;
   wire own_hit;
   wire grp_en;
   wire [2:0] line_sel;
   wire [1:0] mux_gsel;
   wire stat_bit;
   wire [7:0] line_onehot;

   function is_info;
      input [7:0] a;
      begin
         is_info = (a == `GSBS_OFF_INFO_IRQ) ||
                   (a == `GSBS_OFF_INFO_SYNC) ||
                   (a == `GSBS_OFF_INFO_UA) ||
                   (a == `GSBS_OFF_INFO_UB);
      end
   endfunction

   function [1:0] info_code;
      input [7:0] a;
      begin
         if (a == `GSBS_OFF_INFO_IRQ)
            info_code = `GSBS_GSEL_IRQ;
         else if (a == `GSBS_OFF_INFO_SYNC)
            info_code = `GSBS_GSEL_SYNC;
         else if (a == `GSBS_OFF_INFO_UA)
            info_code = `GSBS_GSEL_UA;
         else
            info_code = `GSBS_GSEL_UB;
      end
   endfunction

   assign grp_en = ctrl_one_r[`GSBS_EN_BIT];
   assign line_sel = ctrl_one_r[`GSBS_LSEL_HI:`GSBS_LSEL_LO];
   assign own_hit = rd_i && is_info(addr_i) && grp_en;

   // Register writes; unused bits are stored as zero
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_one_r <= `GSBS_RST_CTRL_ONE;
         ctrl_two_r <= `GSBS_RST_CTRL_TWO;
      end else if (ce_i && wr_i) begin
         if (addr_i == `GSBS_OFF_CTRL_ONE)
            ctrl_one_r <= wdata_i & `GSBS_CTRL_ONE_MASK;
         else if (addr_i == `GSBS_OFF_CTRL_TWO)
            ctrl_two_r <= wdata_i & `GSBS_CTRL_TWO_MASK;
      end
   end

   // Shared pins cross in through two flops each
   gsbs_sync2 #(
      .W(3)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .d_i({group_read_strobe_i, group_sel_line1_i, group_sel_line0_i}),
      .q_o(pin_sync)
   );

   assign peer_gsel = pin_sync[1:0];
   // A strobe we drive ourselves is not a peer request. It comes back
   // through the synchroniser two clocks late, so the echo is masked
   // too; otherwise a finished read would answer itself.
   assign peer_rd = !pin_sync[2] && !own_rd_r && !(|own_echo_r) && grp_en;

   // Own read: encode register on select lines, pull strobe low
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         own_rd_r <= 1'b0;
         own_gsel_r <= 2'h0;
         own_echo_r <= 2'h0;
      end else if (ce_i) begin
         own_rd_r <= own_hit;
         own_echo_r <= {own_echo_r[0], own_rd_r};
         own_gsel_r <= info_code(addr_i);
      end
   end

   // Open drain: only low is driven, high comes from the pull-up
   assign group_sel_line0_o = 1'b0;
   assign group_sel_line1_o = 1'b0;
   assign group_read_strobe_o = 1'b0;
   assign group_sel_line0_oe_o = own_rd_r && !own_gsel_r[0];
   assign group_sel_line1_oe_o = own_rd_r && !own_gsel_r[1];
   assign group_read_strobe_oe_o = own_rd_r;

   assign mux_gsel = own_hit ? info_code(addr_i) : peer_gsel;

   gsbs_status_mux u_mux (
      .gsel_i(mux_gsel),
      .t1_mode_i(t1_mode_i),
      .ua_sel_i(ctrl_two_r[`GSBS_UASEL_HI:`GSBS_UASEL_LO]),
      .ub_sel_i(ctrl_two_r[`GSBS_UBSEL_HI:`GSBS_UBSEL_LO]),
      .irq_i(irq_i),
      .sync_loss_i(sync_loss_i),
      .t1_stat_i(t1_stat_i),
      .e1_stat_i(e1_stat_i),
      .bit_o(stat_bit)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_line
         assign line_onehot[g] = (line_sel == g);
      end
   endgenerate

   // Data lines: plain registers drive all lines, group reads one
   always @* begin
      rdata_nxt = 8'h00;
      oe_nxt = 8'h00;
      if (rd_i && addr_i == `GSBS_OFF_CTRL_ONE) begin
         rdata_nxt = ctrl_one_r;
         oe_nxt = 8'hFF;
      end else if (rd_i && addr_i == `GSBS_OFF_CTRL_TWO) begin
         rdata_nxt = ctrl_two_r;
         oe_nxt = 8'hFF;
      end else if (own_hit || peer_rd) begin
         rdata_nxt = line_onehot & {8{stat_bit}};
         oe_nxt = line_onehot;
      end
   end

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
         oe_r <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= rdata_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign rdata_oe_o = oe_r;
endmodule

// ==== bench/gsbs_peer.sv ====
// Far-side group member that starts group reads on the shared pins.
// Assumes open-drain pins with pull-ups resolved by the bench.
`timescale 1ns/1ps
module gsbs_peer (
   input wire mclk_i, // Clock
   input wire rst_b_i, // Reset, active low
   input wire go_i, // Hold a group read
   input wire [1:0] idx_i, // Register index
   output reg rd_oe_o, // Pulls strobe low
   output reg [1:0] sel_oe_o // Pull select lines low
);
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_oe_o <= 1'b0;
         sel_oe_o <= 2'h0;
      end else begin
         rd_oe_o <= go_i;
         sel_oe_o <= go_i ? ~idx_i : 2'h0;
      end
   end
endmodule

// ==== bench/gsbs_top_sva.sv ====
// Port checker for the group status bus share top module.
// Assumes ce_i high; tracks the control bits from register writes.
`timescale 1ns/1ps
module gsbs_top_sva (
   input wire mclk_i, // Clock
   input wire rst_b_i, // Reset
   input wire [7:0] addr_i, // Address
   input wire [7:0] wdata_i, // Write data
   input wire wr_i, // Write
   input wire rd_i, // Read
   input wire [7:0] rdata_o, // Read data
   input wire [7:0] rdata_oe_o, // Line enables
   input wire irq_i, // Interrupt
   input wire sync_loss_i, // Sync loss
   input wire group_read_strobe_i, // Strobe pin
   input wire group_read_strobe_oe_o, // Strobe pull
   input wire group_sel_line0_oe_o, // Select 0 pull
   input wire group_sel_line1_oe_o // Select 1 pull
);
   reg [3:0] c1_r;
   reg ctl_rd_r; // Control reads may drive every line
   wire [7:0] lane = 8'h01 << c1_r[3:1];
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         c1_r <= 4'h0;
         ctl_rd_r <= 1'b0;
      end else begin
         if (wr_i && addr_i == 8'hB0)
            c1_r <= wdata_i[3:0];
         ctl_rd_r <= rd_i && addr_i < 8'hB2;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence info_any;
      rd_i && c1_r[0] && addr_i > 8'hB1 && addr_i < 8'hB6;
   endsequence
   sequence peer_req;
      (!group_read_strobe_i && !group_read_strobe_oe_o && !rd_i) [*3];
   endsequence
   a_line_select: assert property (info_any |=> rdata_oe_o == $past(lane))
      else $error("wrong data line");
   a_onehot_drive: assert property (!ctl_rd_r |-> $onehot0(rdata_oe_o))
      else $error("several data lines");
   a_disabled_quiet: assert property (!c1_r[0] [*2] ##0 !ctl_rd_r |->
      rdata_oe_o == 8'h00 && !group_read_strobe_oe_o) else $error("disabled");
   a_own_strobe: assert property (info_any |=> group_read_strobe_oe_o &&
      group_sel_line0_oe_o == !$past(addr_i[0]) &&
      group_sel_line1_oe_o == $past(addr_i[1])) else $error("select pins");
   a_irq_bit: assert property (info_any ##0 addr_i == 8'hB2 |=>
      (rdata_o & rdata_oe_o) == ($past(irq_i) ? rdata_oe_o : 8'h00))
      else $error("irq bit");
   a_sync_bit: assert property (info_any ##0 addr_i == 8'hB3 |=>
      (rdata_o & rdata_oe_o) == ($past(sync_loss_i) ? rdata_oe_o : 8'h00))
      else $error("sync bit");
   a_peer_answer: assert property (peer_req ##0 c1_r[0] |=>
      rdata_oe_o == lane) else $error("peer read");
   a_idle_release: assert property ((!rd_i && group_read_strobe_i) [*4] |->
      rdata_oe_o == 8'h00 && !group_sel_line0_oe_o && !group_sel_line1_oe_o)
      else $error("not released");
endmodule
bind gsbs_top gsbs_top_sva gsbs_top_sva_i (.mclk_i, .rst_b_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .rdata_oe_o, .irq_i, .sync_loss_i,
   .group_read_strobe_i, .group_read_strobe_oe_o, .group_sel_line0_oe_o,
   .group_sel_line1_oe_o);

// ==== bench/testbench.sv ====
// Self-checking bench for the group status bus share top module.
// Assumes one peer model on the shared pins and a 4 ns clock.
`timescale 1ns/1ps
module testbench;
   reg mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0;
   reg t1_mode_i = 1'b1, irq_i = 1'b0, sync_loss_i = 1'b0;
   reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   reg [5:0] t1_stat_i = 6'h00, e1_stat_i = 6'h00;
   reg [1:0] idx = 2'h0;
   wire [7:0] rdata_o, rdata_oe_o;
   wire s0_oe, s1_oe, rd_oe, p_rd_oe, s0_o, s1_o, rd_o;
   wire [1:0] p_oe;
   // Pull-ups hold each line high unless a member drives it
   wire s0 = (s0_oe ? s0_o : 1'b1) & ~p_oe[0];
   wire s1 = (s1_oe ? s1_o : 1'b1) & ~p_oe[1];
   wire stb = (rd_oe ? rd_o : 1'b1) & ~p_rd_oe;
   integer errors = 0, checks_done = 0, i, j;
   initial forever #2 mclk_i = ~mclk_i;
   gsbs_top gsbs_top_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .t1_mode_i(t1_mode_i),
      .irq_i(irq_i), .sync_loss_i(sync_loss_i), .t1_stat_i(t1_stat_i),
      .e1_stat_i(e1_stat_i), .group_sel_line0_i(s0),
      .group_sel_line0_o(s0_o), .group_sel_line0_oe_o(s0_oe),
      .group_sel_line1_i(s1), .group_sel_line1_o(s1_o),
      .group_sel_line1_oe_o(s1_oe), .group_read_strobe_i(stb),
      .group_read_strobe_o(rd_o),
      .group_read_strobe_oe_o(rd_oe));
   gsbs_peer gsbs_peer_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .go_i(go),
      .idx_i(idx), .rd_oe_o(p_rd_oe), .sel_oe_o(p_oe));
   task chk(input [63:0] what, input [7:0] seen, exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, d);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge mclk_i);
         wr_i <= 1'b0;
      end
   endtask
   // Data bits are judged only on lines this member should drive
   task rdc(input [7:0] a, ed, eo);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge mclk_i);
         @(negedge mclk_i);
         if (a < 8'hB2) begin
            chk("rdata", rdata_o, ed);
            chk("ctl_oe", rdata_oe_o, 8'hFF);
         end else begin
            chk("bit", rdata_o & eo, ed);
            chk("line_oe", rdata_oe_o, eo);
         end
         @(posedge mclk_i);
         rd_i <= 1'b0;
      end
   endtask
   task t_regs;
      begin
         rdc(8'hB0, 8'h00, 8'h00);
         wr(8'hB0, 8'h0E);
         rdc(8'hB0, 8'h0E, 8'h00);
         wr(8'hB1, 8'h77);
         rdc(8'hB1, 8'h77, 8'h00);
         irq_i <= 1'b1;
         rdc(8'hB2, 8'h00, 8'h00);
         wr(8'hB0, 8'h01);
         rdc(8'hB6, 8'h00, 8'h00);
      end
   endtask
   task t_lanes;
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'hB0, {4'h0, i[2:0], 1'b1});
         irq_i <= i[0];
         sync_loss_i <= ~i[0];
         rdc(8'hB2, {7'h00, i[0]} << i, 8'h01 << i);
         rdc(8'hB3, {7'h00, ~i[0]} << i, 8'h01 << i);
      end
   endtask
   // One alarm set in the chosen mode for c below 6, the inverse in the other
   task put_stat(input m, input [2:0] c);
      begin
         t1_stat_i <= m ? 6'h01 << c : ~(6'h01 << c);
         e1_stat_i <= m ? ~(6'h01 << c) : 6'h01 << c;
      end
   endtask
   // Lane 7 stays selected; the two selects differ so a swap shows
   task t_codes;
      for (j = 0; j < 16; j = j + 1) begin
         t1_mode_i <= j[3];
         put_stat(j[3], j[2:0]);
         wr(8'hB1, {1'b0, j[2:0] ^ 3'h1, 1'b0, j[2:0]});
         rdc(8'hB4, {j[2:0] < 6, 7'h00}, 8'h80);
         put_stat(j[3], j[2:0] ^ 3'h1);
         rdc(8'hB5, {j[2:0] < 6, 7'h00}, 8'h80);
      end
   endtask
   task t_peer;
      begin
         // The peer owns no data line, so no two members share one
         wr(8'hB1, 8'h10);
         t1_stat_i <= 6'h02;
         irq_i <= 1'b0;
         sync_loss_i <= 1'b1;
         for (i = 0; i < 4; i = i + 1) begin
            idx <= i[1:0];
            go <= 1'b1;
            repeat (5) @(posedge mclk_i);
            @(negedge mclk_i);
            chk("peer_oe", rdata_oe_o, 8'h80);
            chk("peer_bit", rdata_o & 8'h80, {i[0], 7'h00});
            @(posedge mclk_i);
            go <= 1'b0;
            repeat (5) @(posedge mclk_i);
            @(negedge mclk_i);
            chk("peer_off", rdata_oe_o, 8'h00);
            @(posedge mclk_i);
         end
      end
   endtask
   task give_verdict;
      begin
         if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      t_regs;
      t_lanes;
      t_codes;
      t_peer;
      give_verdict;
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      errors = errors + 1;
      give_verdict;
   end
endmodule
